// ==== hdl/mtc_pkg.sv ====
// Shared types and constants for the transmit-side parallel MII capture.
// Assumes one core clock; the TXCLK half period this end drives is derived from its period.
package mtc_pkg;

    typedef enum logic [2:0] {
        MTC_MODE_MII        = 3'b000,
        MTC_MODE_GMII       = 3'b001,
        MTC_MODE_RGMII_10   = 3'b010,
        MTC_MODE_RGMII_100  = 3'b011,
        MTC_MODE_RGMII_1000 = 3'b100
    } mtc_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic en;
        logic er;
    } mtc_word_t;

    localparam int MTC_CORE_CLK_NS = 50;
    // Half period of the TXCLK this end drives when it owns the clock
    localparam int MTC_TXCLK_HALF_NS = 200;
    localparam int MTC_TXCLK_HALF_CYC_I =
        (MTC_TXCLK_HALF_NS + MTC_CORE_CLK_NS - 1) / MTC_CORE_CLK_NS;
    localparam logic [7:0] MTC_TXCLK_HALF_CYC = MTC_TXCLK_HALF_CYC_I[7:0];

    localparam logic [3:0] MTC_GPIO_RESET = 4'h0;
    localparam mtc_word_t MTC_WORD_RESET = '0;

endpackage

// ==== hdl/mtc_capture.sv ====
// Transmit capture from a MAC on the parallel MII: GMII, MII, RGMII.
// Assumes pins and the link clocks are asynchronous to core_clk and that
// core_clk is well above twice the active transmit clock rate.
// Notes on behaviour
// - GMII: all eight data pins taken on each GTXCLK rising edge.
// - MII, RGMII-10/100: low nibble taken on TXCLK or GTXCLK rise.
// - Four-bit modes turn upper data pins into general-purpose pins 4-7.
// - RGMII-1000: low nibble on GTXCLK rise, high nibble on next fall.
// - MII/GMII: transmit enable taken on rising edge of the active clock.
// - RGMII-1000: control pin sampled on both GTXCLK edges; RGMII-10/100 on successive rises.
// - MII/GMII: transmit error taken on rising edge of active clock.
// - RGMII: separate error pin ignored; error comes from control pin.
// - MII TXCLK is partner input at role 1, driven here at role 0.
`timescale 1ns/1ps
module mtc_capture
    import mtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire mtc_mode_t mode_sel,
    input wire logic link_role_select,
    input wire logic gtxclk,
    input wire logic txclk_in,
    output logic txclk_out,
    output logic txclk_oe,
    input wire logic [3:0] txd_lo,
    input wire logic [3:0] txd_hi_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    input wire logic [3:0] gpio_out_req,
    input wire logic [3:0] gpio_oe_req,
    output logic [3:0] gpio_in,
    input wire logic tx_en_pin,
    input wire logic tx_er_pin,
    output mtc_word_t tx_word,
    output logic tx_word_valid
);

    // Two-stage synchronisers; stage b feeds logic, stage c finds edges
    logic [11:0] pin_a_reg;
    logic [11:0] pin_b_reg;
    logic [11:0] pin_a_next;
    logic [11:0] pin_b_next;
    logic gclk_c_reg;
    logic tclk_c_reg;
    logic gclk_c_next;
    logic tclk_c_next;

    always_comb
    begin
        pin_a_next = {gtxclk, txclk_in, tx_en_pin, tx_er_pin,
                      txd_hi_in, txd_lo};
        pin_b_next = pin_a_reg;
        gclk_c_next = pin_b_reg[11];
        tclk_c_next = pin_b_reg[10];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_a_reg <= '0;
            pin_b_reg <= '0;
            gclk_c_reg <= 1'b0;
            tclk_c_reg <= 1'b0;
        end
        else
        begin
            pin_a_reg <= pin_a_next;
            pin_b_reg <= pin_b_next;
            gclk_c_reg <= gclk_c_next;
            tclk_c_reg <= tclk_c_next;
        end
    end

    logic s_gclk;
    logic s_tclk;
    logic s_en;
    logic s_er;
    logic [3:0] s_hi;
    logic [3:0] s_lo;
    assign {s_gclk, s_tclk, s_en, s_er, s_hi, s_lo} = pin_b_reg;

    logic is_mii;
    logic is_gmii;
    logic is_ddr;
    logic is_nibble;
    logic act_rise;
    logic act_fall;
    assign is_mii = (mode_sel == MTC_MODE_MII);
    assign is_gmii = (mode_sel == MTC_MODE_GMII);
    assign is_ddr = (mode_sel == MTC_MODE_RGMII_10) ||
                    (mode_sel == MTC_MODE_RGMII_100) ||
                    (mode_sel == MTC_MODE_RGMII_1000);
    assign is_nibble = !is_gmii;
    // Active transmit clock: TXCLK for MII, GTXCLK otherwise
    assign act_rise = is_mii ? (s_tclk && !tclk_c_reg)
                             : (s_gclk && !gclk_c_reg);
    assign act_fall = !s_gclk && gclk_c_reg;

    // TXCLK generator, used only when this end owns the MII clock
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic tclk_drv_reg;
    logic tclk_drv_next;
    logic tclk_oe_reg;
    logic tclk_oe_next;

    always_comb
    begin
        div_next = div_reg + 8'h01;
        tclk_drv_next = tclk_drv_reg;
        if (div_reg >= MTC_TXCLK_HALF_CYC - 8'h01)
        begin
            div_next = 8'h00;
            tclk_drv_next = !tclk_drv_reg;
        end
        tclk_oe_next = is_mii && !link_role_select;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            div_reg <= 8'h00;
            tclk_drv_reg <= 1'b0;
            tclk_oe_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            tclk_drv_reg <= tclk_drv_next;
            tclk_oe_reg <= tclk_oe_next;
        end
    end

    assign txclk_out = tclk_drv_reg;
    assign txclk_oe = tclk_oe_reg;

    // Upper data pins double as general-purpose pins in nibble modes
    logic [3:0] gout_reg;
    logic [3:0] goe_reg;
    logic [3:0] gin_reg;
    logic [3:0] gout_next;
    logic [3:0] goe_next;
    logic [3:0] gin_next;

    always_comb
    begin
        gout_next = gpio_out_req;
        goe_next = is_nibble ? gpio_oe_req : 4'h0;
        gin_next = is_nibble ? s_hi : 4'h0;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            gout_reg <= MTC_GPIO_RESET;
            goe_reg <= MTC_GPIO_RESET;
            gin_reg <= MTC_GPIO_RESET;
        end
        else
        begin
            gout_reg <= gout_next;
            goe_reg <= goe_next;
            gin_reg <= gin_next;
        end
    end

    assign gpio_out = gout_reg;
    assign gpio_oe = goe_reg;
    assign gpio_in = gin_reg;

    // Byte assembly
    logic [3:0] low_reg;
    logic [3:0] low_next;
    logic ctl_r_reg;
    logic ctl_r_next;
    logic half_reg;
    logic half_next;
    logic prev_en_reg;
    logic prev_en_next;
    mtc_word_t word_reg;
    mtc_word_t word_next;
    logic valid_reg;
    logic valid_next;

    always_comb
    begin
        low_next = low_reg;
        ctl_r_next = ctl_r_reg;
        half_next = half_reg;
        prev_en_next = prev_en_reg;
        word_next = word_reg;
        valid_next = 1'b0;
        unique case (mode_sel)
            MTC_MODE_GMII:
            begin
                if (act_rise)
                begin
                    word_next.data = {s_hi, s_lo};
                    word_next.en = s_en;
                    word_next.er = s_er;
                    valid_next = 1'b1;
                end
            end
            MTC_MODE_RGMII_1000:
            begin
                if (act_rise)
                begin
                    low_next = s_lo;
                    ctl_r_next = s_en;
                    half_next = 1'b1;
                end
                else if (act_fall && half_reg)
                begin
                    word_next.data = {s_lo, low_reg};
                    word_next.en = ctl_r_reg;
                    // Error pin unused; error is the change of control
                    word_next.er = ctl_r_reg ^ s_en;
                    half_next = 1'b0;
                    valid_next = 1'b1;
                end
            end
            default:
            begin
                // MII and RGMII-10/100 share nibble pairing
                if (act_rise)
                begin
                    prev_en_next = s_en;
                    // A frame start always opens on the low nibble
                    if (!half_reg || (s_en && !prev_en_reg))
                    begin
                        low_next = s_lo;
                        ctl_r_next = s_en;
                        half_next = 1'b1;
                    end
                    else
                    begin
                        word_next.data = {s_lo, low_reg};
                        word_next.en = ctl_r_reg;
                        word_next.er = is_ddr ? (ctl_r_reg ^ s_en)
                                              : s_er;
                        half_next = 1'b0;
                        valid_next = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            low_reg <= 4'h0;
            ctl_r_reg <= 1'b0;
            half_reg <= 1'b0;
            prev_en_reg <= 1'b0;
            word_reg <= MTC_WORD_RESET;
            valid_reg <= 1'b0;
        end
        else
        begin
            low_reg <= low_next;
            ctl_r_reg <= ctl_r_next;
            half_reg <= half_next;
            prev_en_reg <= prev_en_next;
            word_reg <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign tx_word = word_reg;
    assign tx_word_valid = valid_reg;

endmodule

// ==== dv/mtc_assertions.sv ====
// Port timing checks for mtc_capture.
// Assumes a bind to every mtc_capture instance.
`timescale 1ns/1ps
module mtc_assertions
    import mtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire mtc_mode_t mode_sel,
    input wire logic link_role_select,
    input wire logic gtxclk,
    input wire logic txclk_out,
    input wire logic txclk_oe,
    input wire logic [3:0] txd_lo,
    input wire logic [3:0] txd_hi_in,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] gpio_out_req,
    input wire logic [3:0] gpio_oe_req,
    input wire logic [3:0] gpio_in,
    input wire logic tx_en_pin,
    input wire logic tx_er_pin,
    input wire mtc_word_t tx_word,
    input wire logic tx_word_valid
);
    logic gm;
    assign gm = mode_sel == MTC_MODE_GMII;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_valid_pulse: assert property (tx_word_valid |=> !tx_word_valid)
        else $error("valid held too long");
    a_gmii_data: assert property (gm && tx_word_valid |->
        tx_word == {$past({txd_hi_in, txd_lo, tx_en_pin, tx_er_pin}, 3)})
        else $error("gmii word differs from pins");
    a_gmii_latency: assert property ($rose(gtxclk) && gm |->
        ##[1:3] tx_word_valid) else $error("gmii word late");
    a_gmii_nofall: assert property ($fell(gtxclk) && gm |=>
        !tx_word_valid[*3]) else $error("word from falling edge");
    a_gpio_gmii: assert property (gm && $past(gm) |->
        gpio_oe == 4'h0 && gpio_in == 4'h0) else $error("gpio live in gmii");
    a_gpio_oe: assert property (!$past(rst) && !gm && !$past(gm) |->
        gpio_oe == $past(gpio_oe_req)) else $error("gpio enable lag");
    a_gpio_out: assert property (!$past(rst) |->
        gpio_out == $past(gpio_out_req)) else $error("gpio out lag");
    a_gpio_in: assert property (!$past(rst) && !$past(rst, 3) && !gm
        && !$past(gm, 3) |-> gpio_in == $past(txd_hi_in, 3))
        else $error("gpio in lag");
    a_txclk_oe: assert property (!$past(rst) |-> txclk_oe ==
        $past(mode_sel == MTC_MODE_MII && !link_role_select))
        else $error("txclk enable wrong");
    a_txclk_half: assert property ($rose(txclk_out) && txclk_oe |=>
        txclk_out[*3] ##1 !txclk_out) else $error("txclk half period");
endmodule
bind mtc_capture mtc_assertions mtc_assertions_inst (.*);

// ==== dv/mtc_mac_model.sv ====
// MAC side of the transmit MII: clocks, data and qualifiers.
// Assumes send is called off the core clock edges, after reset.
`timescale 1ns/1ps
module mtc_mac_model
    import mtc_pkg::*;
(
    input wire mtc_mode_t mode_sel,
    output logic gtxclk,
    output logic txclk,
    output logic [7:0] txd,
    output logic tx_en,
    output logic tx_er
);
    initial
    begin
        gtxclk = 1'b0;
        txclk = 1'b0;
        txd = 8'h00;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end
    // Edges sit mid-way between data changes; clock idles low
    task automatic step(input logic [7:0] d, input logic c, input logic k);
        txd = d;
        tx_en = c;
        #100;
        if (mode_sel == MTC_MODE_MII)
            txclk = k;
        else
            gtxclk = k;
        #100;
    endtask
    task automatic send(input logic [7:0] b, input logic en, input logic er);
        logic c2;
        c2 = (mode_sel == MTC_MODE_MII) ? en : en ^ er;
        // Error pin held high in RGMII so a leak shows
        tx_er = (mode_sel > MTC_MODE_GMII) ? 1'b1 : er;
        if (mode_sel == MTC_MODE_GMII)
        begin
            step(b, en, 1'b1);
            step(b, en, 1'b0);
        end
        else if (mode_sel == MTC_MODE_RGMII_1000)
        begin
            step({~b[3:0], b[3:0]}, en, 1'b1);
            step({~b[7:4], b[7:4]}, c2, 1'b0);
        end
        else
        begin
            step({~b[3:0], b[3:0]}, en, 1'b1);
            step({b[3:0], b[3:0]}, en, 1'b0);
            step({~b[7:4], b[7:4]}, c2, 1'b1);
            step({b[7:4], b[7:4]}, c2, 1'b0);
        end
    endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for mtc_capture with a MAC model.
// Assumes 20 MHz core clock and a 2.5 MHz link clock.
`timescale 1ns/1ps
module tb;
    import mtc_pkg::*;
    logic core_clk, rst, role, gtxclk, mclk, txclk_out, txclk_oe;
    logic tx_en, tx_er, tx_word_valid;
    logic [7:0] txd;
    logic [3:0] gpio_out, gpio_oe, gpio_out_req, gpio_oe_req, gpio_in, hi;
    mtc_mode_t mode_sel;
    mtc_word_t tx_word;
    mtc_word_t got[$];
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    assign hi = (gpio_oe & gpio_out) | (~gpio_oe & txd[7:4]);
    mtc_capture mtc_capture_inst (.core_clk(core_clk), .rst(rst),
        .mode_sel(mode_sel), .link_role_select(role), .gtxclk(gtxclk),
        .txclk_in(txclk_oe ? txclk_out : mclk), .txclk_out(txclk_out),
        .txclk_oe(txclk_oe), .txd_lo(txd[3:0]), .txd_hi_in(hi),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_out_req(gpio_out_req),
        .gpio_oe_req(gpio_oe_req), .gpio_in(gpio_in), .tx_en_pin(tx_en),
        .tx_er_pin(tx_er), .tx_word(tx_word), .tx_word_valid(tx_word_valid));
    mtc_mac_model mtc_mac_model_inst (.mode_sel(mode_sel), .gtxclk(gtxclk),
        .txclk(mclk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Outputs are taken mid-cycle, away from the edge that launches them
    always @(negedge core_clk)
    begin
        cyc++;
        if (tx_word_valid === 1'b1 && tx_word.en === 1'b1)
            got.push_back(tx_word);
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic cmp(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic restart(input mtc_mode_t m, input logic r);
        @(negedge core_clk);
        rst = 1'b1;
        mode_sel = m;
        role = r;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        repeat (6) @(negedge core_clk);
        got.delete();
    endtask
    task automatic test_frames();
        for (int m = 0; m < 5; m++)
        begin
            restart(mtc_mode_t'(m), 1'b1);
            mtc_mac_model_inst.send(8'h00, 1'b0, 1'b0);
            mtc_mac_model_inst.send(8'hA5, 1'b1, 1'b0);
            mtc_mac_model_inst.send(8'h3C, 1'b1, 1'b1);
            mtc_mac_model_inst.send(8'h00, 1'b0, 1'b0);
            repeat (8) @(negedge core_clk);
            cmp("word count", 10'h002, 10'(got.size()));
            if (got.size() == 2)
            begin
                cmp("word 0", 10'h296, got[0]);
                cmp("word 1", 10'h0F3, got[1]);
            end
        end
    endtask
    task automatic test_gpio();
        restart(MTC_MODE_RGMII_100, 1'b1);
        gpio_oe_req = 4'h5;
        gpio_out_req = 4'h3;
        repeat (4) @(negedge core_clk);
        cmp("gpio oe", 10'h005, 10'(gpio_oe));
        cmp("gpio out", 10'h003, 10'(gpio_out));
        cmp("gpio in", 10'(4'h1 | (4'hA & txd[7:4])), 10'(gpio_in));
        restart(MTC_MODE_GMII, 1'b1);
        cmp("gmii oe", 10'h000, 10'(gpio_oe));
    endtask
    task automatic test_clock();
        int rises;
        logic prev;
        rises = 0;
        restart(MTC_MODE_MII, 1'b0);
        cmp("txclk oe", 10'h001, 10'(txclk_oe));
        prev = txclk_out;
        // 32 intervals span whole periods, so the count is phase-free
        for (int i = 0; i < 32; i++)
        begin
            @(negedge core_clk);
            if (txclk_out === 1'b1 && prev === 1'b0)
                rises++;
            prev = txclk_out;
        end
        cmp("txclk rises", 10'(32 / (2 * MTC_TXCLK_HALF_CYC)),
            10'(rises));
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        role = 1'b1;
        mode_sel = MTC_MODE_GMII;
        gpio_out_req = 4'h0;
        gpio_oe_req = 4'h0;
        test_frames();
        test_gpio();
        test_clock();
        complete_run();
    end
endmodule
